// File: dv/smc_slave_model.sv
// Purpose: serial slave facing the core while the core is master
// Assumes: format taken from the same idle level and phase bits
// Notes: a released miso shows the inverse of its last bit
module smc_slave_model (
	input wire logic csN,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic clock_idle_level,
	input wire logic capLead,
	input wire logic [7:0] txWord,
	output logic miso,
	output logic [7:0] rxWord
);
	timeunit 1ns;
	timeprecision 100ps;
	int shifts = 0;
	int idx;
	initial begin
		miso = 1'b0;
		rxWord = 8'h00;
	end
	// selection presents the msb, release inverts the line
	always @(csN) begin
		shifts = 0;
		miso = csN ? ~miso : txWord[7];
	end
	// capture on the agreed edge, shift out on the other one
	always @(sclk) begin
		if (!csN && sclk === (clock_idle_level ^ capLead)) begin
			rxWord = {rxWord[6:0], mosi};
		end else if (!csN) begin
			shifts = shifts + 1;
			idx = (capLead ? shifts : shifts - 1) % 8;
			miso = txWord[7 - idx];
		end
	end
endmodule : smc_slave_model

// File: dv/spi_master_slave_core_tb_top.sv
// Purpose: self-checking bench of the serial master/slave core
// Assumes: 40 MHz clock, synchronous active-high reset
// Notes: random words come from an lfsr with a fixed start value
module spi_master_slave_core_tb_top import smc_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0;
	logic srst, enable, msel, clock_idle_level, capLead, txWrite, rxRead, statusRead;
	logic [7:0] baudDiv, dly, txData, modelTx, modelRx, rxData;
	logic [3:0] psel, intEn, csN, csOe;
	logic tbSclk, tbMosi, tbSsnN, modelMiso, tx_all_done, allDone, rxFull;
	logic ovr, dmaReq, irq, sclkOut, sclkOe, mosiOut, mosiOe, misoOut;
	logic misoOe, sclkW, mosiW, misoW, ssnW, csModel;
	logic [31:0] seed = 32'hAFEEEF95;
	int error_cnt = 0;
	int comparisons = 0;
	// free-running clock of 25 ns
	initial begin
		forever #12.5 clock = ~clock;
	end
	// wire levels from every party's enables
	assign sclkW = sclkOe ? sclkOut : tbSclk;
	assign mosiW = mosiOe ? mosiOut : tbMosi;
	assign misoW = misoOe ? misoOut : modelMiso;
	assign ssnW = csOe[0] ? csN[0] : tbSsnN;
	assign csModel = csN[0] | ~csOe[0];
	smc_core u_smc_core (.clock(clock), .srst(srst), .enable(enable),
		.masterSelectBit(msel), .clockIdleLevel(clock_idle_level),
		.captureLeadingEdge(capLead), .baudDivisor(baudDiv),
		.interTransferDelay(dly), .peripheralSelectField(psel),
		.intEnable(intEn), .txWrite(txWrite), .txData(txData),
		.rxRead(rxRead), .statusRead(statusRead), .rxData(rxData),
		.txHoldingEmpty(tx_all_done), .txAllDone(allDone),
		.rxHoldingFull(rxFull), .rxOverrunFlag(ovr), .dmaTxReq(dmaReq),
		.irq(irq), .sclkIn(sclkW), .sclkOut(sclkOut), .sclkOe(sclkOe),
		.mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe),
		.misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe),
		.slaveSelectN(ssnW), .chipSelectN(csN), .chipSelectOe(csOe));
	smc_slave_model u_smc_slave_model (.csN(csModel), .sclk(sclkW),
		.mosi(mosiW), .clock_idle_level(clock_idle_level), .capLead(capLead), .txWord(modelTx),
		.miso(modelMiso), .rxWord(modelRx));
	// next lfsr value
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// lowest zero bit of the select field drives its line low
	function automatic logic [3:0] cs_expect(input logic [3:0] p);
		for (int i = 0; i < 4; i++) begin
			if (!p[i]) begin
				return ~(4'h1 << i);
			end
		end
		return 4'hF;
	endfunction : cs_expect
	task automatic rnd(output logic [7:0] v);
		seed = lfsr(seed);
		v = seed[7:0];
	endtask : rnd
	task automatic tally_and_finish;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("BAD %s exp %h got %h", what, exp, got);
			error_cnt++;
		end
	endtask : check
	// bounded wait for a flag, sampled at the falling edge
	// flag select: 0 transfer done, 1 holding empty, 2 receive full
	task automatic wait_hi(input int w, input int lim);
		logic v;
		v = 1'b0;
		for (int n = 0; n < lim; n++) begin
			@(negedge clock);
			v = (w == 0) ? allDone : ((w == 1) ? tx_all_done : rxFull);
			if (v === 1'b1) begin
				return;
			end
		end
		$display("BAD wait exp 1 got %b", v);
		error_cnt++;
		tally_and_finish();
	endtask : wait_hi
	// one-cycle pulse: 0 write, 1 receive read, 2 status read
	task automatic strobe(input int k, input logic [7:0] d);
		@(posedge clock);
		txData <= d;
		{txWrite, rxRead, statusRead} <= 3'b100 >> k;
		@(posedge clock);
		{txWrite, rxRead, statusRead} <= 3'b000;
	endtask : strobe
	// master transfer of one word, chip select looked at in the first bit
	task automatic xfer(input logic [7:0] d, input logic [3:0] cs);
		strobe(0, d);
		repeat (3) @(negedge clock);
		check("cs", {4'h0, cs}, {4'h0, csN});
		wait_hi(0, 4000);
	endtask : xfer
	// main sequence
	initial begin
		logic [7:0] d, m, got;
		logic [3:0] p;
		int n;
		{srst, enable, msel, clock_idle_level, capLead} = 5'b10101;
		{txWrite, rxRead, statusRead, tbSclk, tbMosi, tbSsnN} = 6'h01;
		{baudDiv, dly, txData, modelTx} = {8'h04, 24'h000000};
		{psel, intEn} = 8'hE4;
		repeat (2) @(posedge clock);
		{srst, enable} <= 2'b01;
		@(negedge clock);
		check("rst", 8'hCF, {tx_all_done, allDone, rxFull, ovr, csN});
		check("rstoe", 8'h00, {csOe, sclkOe, mosiOe, misoOe});
		repeat (2) @(negedge clock);
		check("moe", 8'h7E, {csOe, sclkOe, mosiOe, misoOe});
		// all four formats with random words both ways
		for (int f = 0; f < 4; f++) begin
			rnd(d);
			rnd(m);
			@(posedge clock);
			{clock_idle_level, capLead} <= f[1:0];
			modelTx <= m;
			repeat (3) @(negedge clock);
			check("idle", {7'h00, f[1]}, {7'h00, sclkOut});
			xfer(d, 4'hE);
			check("rx", m, rxData);
			check("mrx", d, modelRx);
			check("full", 8'h03, {6'h00, rxFull, irq});
			strobe(1, 8'h00);
			@(negedge clock);
			check("rdr", 8'h00, {6'h00, rxFull, irq});
		end
		// each chip select in turn, upper select bits random
		for (int k = 0; k < 4; k++) begin
			rnd(d);
			p = (d[3:0] | ((4'h1 << k) - 4'h1)) & ~(4'h1 << k);
			@(posedge clock);
			psel <= p;
			xfer(d, cs_expect(p));
		end
		rnd(d);
		rnd(m);
		@(posedge clock);
		{psel, dly, modelTx} <= {4'hE, 8'h05, m};
		strobe(1, 8'h00);
		strobe(2, 8'h00);
		// second word written while the first is shifting
		strobe(0, d);
		repeat (6) @(negedge clock);
		strobe(0, ~d);
		@(negedge clock);
		check("hold", 8'h00, {6'h00, tx_all_done, dmaReq});
		wait_hi(1, 400);
		check("chain", 8'h0E, {3'h0, allDone, csN});
		wait_hi(0, 400);
		check("ovr", 8'h03, {6'h00, ovr, rxFull});
		check("rx2", m, rxData);
		check("mrx2", ~d, modelRx);
		strobe(1, 8'h00);
		@(negedge clock);
		check("ovrrd", 8'h01, {7'h00, ovr});
		strobe(2, 8'h00);
		@(negedge clock);
		check("ovrst", 8'h00, {7'h00, ovr});
		// delay from word landing to transfer done
		strobe(0, d);
		wait_hi(2, 400);
		n = 0;
		while (allDone !== 1'b1 && n < 50) begin
			@(negedge clock);
			n++;
		end
		check("gap", 8'h06, n[7:0]);
		// slave mode, bench acts as the far master
		// all four formats; mosi changes on the shift edge while selected and toggles at release
		for (int f = 0; f < 4; f++) begin
			rnd(d);
			rnd(m);
			@(posedge clock);
			{msel, clock_idle_level, capLead, tbSclk} <= {1'b0, f[1], f[0], f[1]};
			strobe(0, d);
			repeat (4) @(negedge clock);
			check("soe", 8'h00, {3'h0, csOe[3:1], sclkOe, mosiOe});
			@(posedge clock);
			tbSsnN <= 1'b0;
			for (int i = 7; i >= 0; i--) begin
				if (capLead) begin
					tbMosi <= m[i];
				end
				repeat (6) @(posedge clock);
				if (capLead) begin
					got[i] = misoW;
				end
				tbSclk <= ~clock_idle_level;
				if (!capLead) begin
					tbMosi <= m[i];
				end
				repeat (6) @(posedge clock);
				if (!capLead) begin
					got[i] = misoW;
				end
				tbSclk <= clock_idle_level;
			end
			check("misooe", 8'h01, {7'h00, misoOe});
			repeat (6) @(posedge clock);
			tbSsnN <= 1'b1;
			tbMosi <= ~tbMosi;
			@(negedge clock);
			check("stx", d, got);
			check("srx", m, rxData);
		end
		tally_and_finish();
	end
endmodule : spi_master_slave_core_tb_top

// File: shared/smc_pkg.sv
// Purpose: shared types and constants of the serial master/slave core
// Assumes: 8-bit words, most significant bit first, 40 MHz system clock
// Notes: one-hot state codes, pin order of the input synchroniser below
package smc_pkg;

	// data word layout
	localparam int WORD_W = 8;
	localparam int MSB = WORD_W - 1;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int CLK_PERIOD_NS = 25;

	// chip-select codes
	localparam logic [3:0] CS_IDLE = 4'hF;
	localparam logic [3:0] CS_ALL_OE = 4'hF;
	localparam logic [3:0] CS_NO_OE = 4'h0;

	// synchroniser lanes
	localparam int SYNC_W = 4;
	localparam int SY_SCLK = 0;
	localparam int SY_MOSI = 1;
	localparam int SY_MISO = 2;
	localparam int SY_SSN = 3;

	// master sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LEAD = 4'b0010,
		ST_TRAIL = 4'b0100,
		ST_GAP = 4'b1000
	} smc_fsm_t;

	// whole state of the core
	typedef struct packed {
		smc_fsm_t fsm;
		logic [7:0] cnt;
		logic [2:0] bitCnt;
		logic [WORD_W-1:0] sh;
		logic sample;
		logic [WORD_W-1:0] hold;
		logic txHoldingEmpty;
		logic [WORD_W-1:0] rx;
		logic rxHoldingFull;
		logic rxOverrunFlag;
		logic txAllDone;
		logic sclkP;
		logic ssnP;
		logic outBit;
		logic sclkQ;
		logic [3:0] csN;
		logic [3:0] csOe;
		logic sclkOe;
		logic mosiOe;
		logic misoOe;
		logic irq;
	} smc_state_t;

	localparam smc_state_t SMC_RESET = '{
		fsm: ST_IDLE, cnt: 8'h00, bitCnt: 3'h0, sh: 8'h00, sample: 1'b0,
		hold: 8'h00, txHoldingEmpty: 1'b1, rx: 8'h00, rxHoldingFull: 1'b0,
		rxOverrunFlag: 1'b0, txAllDone: 1'b1, sclkP: 1'b0, ssnP: 1'b1,
		outBit: 1'b0, sclkQ: 1'b0, csN: 4'hF, csOe: 4'h0, sclkOe: 1'b0,
		mosiOe: 1'b0, misoOe: 1'b0, irq: 1'b0};

	// synchroniser state
	typedef struct packed {
		logic [SYNC_W-1:0] meta;
		logic [SYNC_W-1:0] stable;
	} smc_sync_t;

	localparam smc_sync_t SYNC_RESET = '{meta: 4'hF, stable: 4'hF};

endpackage : smc_pkg

// File: src/smc_core.sv
// Purpose: serial peripheral core, master or slave, 8-bit words
// Assumes: 40 MHz clock; control bits arrive as plain ports on this clock
// Notes: pins enter through smc_sync; every output is a flip-flop
// Summary of operation
// - master select 1: chip selects, clock and MOSI driven; MISO received
// - master select 0: MISO driven only while enabled and selected, MOSI received, slave select input
// - in slave mode all four chip-select pins 0 to 3 stay undriven
// - baud counter runs only in master mode
// - same format settings serve master and slave
// - idle level and phase pick one of four formats
// - idle level 0 low, 1 high; phase 1 captures leading edge
// - master makes clock, drives chip select, runs the transfer
// - transmit holding, receive holding and one shared shift register
// - master write while idle moves word to shifter and starts a transfer; slave loads it at selection
// - each shifted-out bit is matched by a sampled input bit
// - word written mid-transfer waits, then loads and starts at completion
// - holding-empty sets on load to shifter, clears on each write
// - holding-empty is the transmit DMA request
// - transfer-done sets at end, in master mode after the inter-transfer delay
// - receive-full sets on receive load, clears on receive read
// - unread word overwritten sets overrun; receive keeps updating
// - overrun clears only on a status read
// - master clock divided by twice the divisor 1 to 255; zero acts as one
// - delay inserted between consecutive transfers on one chip select
module smc_core import smc_pkg::*; (
	input wire logic clock,
	input wire logic srst,
	input wire logic enable,
	input wire logic masterSelectBit,
	input wire logic clockIdleLevel,
	input wire logic captureLeadingEdge,
	input wire logic [7:0] baudDivisor,
	input wire logic [7:0] interTransferDelay,
	input wire logic [3:0] peripheralSelectField,
	input wire logic [3:0] intEnable,
	input wire logic txWrite,
	input wire logic [WORD_W-1:0] txData,
	input wire logic rxRead,
	input wire logic statusRead,
	output logic [WORD_W-1:0] rxData,
	output logic txHoldingEmpty,
	output logic txAllDone,
	output logic rxHoldingFull,
	output logic rxOverrunFlag,
	output logic dmaTxReq,
	output logic irq,
	input wire logic sclkIn,
	output logic sclkOut,
	output logic sclkOe,
	input wire logic mosiIn,
	output logic mosiOut,
	output logic mosiOe,
	input wire logic misoIn,
	output logic misoOut,
	output logic misoOe,
	input wire logic slaveSelectN,
	output logic [3:0] chipSelectN,
	output logic [3:0] chipSelectOe
);
	smc_state_t s;
	smc_state_t n;
	logic [SYNC_W-1:0] syn;
	logic lead;
	logic trail;
	logic rxLoad;
	logic startXfer;
	logic inBit;
	logic [WORD_W-1:0] shNew;

	// end of one half bit period; a zero divisor behaves as one
	function automatic logic halfDone(input logic [7:0] cnt,
		input logic [7:0] div);
		halfDone = ({1'b0, cnt} + 9'h001) >= {1'b0, div};
	endfunction : halfDone

	// lowest numbered zero bit selects the one active chip select
	function automatic logic [3:0] csDecode(input logic [3:0] peripheral_select_field);
		if (!peripheral_select_field[0]) begin
			csDecode = 4'hE;
		end else if (!peripheral_select_field[1]) begin
			csDecode = 4'hD;
		end else if (!peripheral_select_field[2]) begin
			csDecode = 4'hB;
		end else if (!peripheral_select_field[3]) begin
			csDecode = 4'h7;
		end else begin
			csDecode = CS_IDLE;
		end
	endfunction : csDecode

	// one shift step, new bit enters at the bottom
	function automatic logic [WORD_W-1:0] shiftIn(
		input logic [WORD_W-1:0] sh, input logic b);
		shiftIn = {sh[WORD_W-2:0], b};
	endfunction : shiftIn

	// pin inputs pass two flip-flops first
	smc_sync u_sync (
		.clock(clock),
		.srst(srst),
		.pinIn({slaveSelectN, misoIn, mosiIn, sclkIn}),
		.pinSync(syn)
	);

	// next-state logic of the whole core
	always_comb begin
		n = s;
		lead = 1'b0;
		trail = 1'b0;
		rxLoad = 1'b0;
		startXfer = 1'b0;
		shNew = s.sh;
		n.sclkP = syn[SY_SCLK];
		n.ssnP = syn[SY_SSN];
		// pin directions follow the role
		n.sclkOe = masterSelectBit;
		n.mosiOe = masterSelectBit;
		n.csOe = masterSelectBit ? CS_ALL_OE : CS_NO_OE;
		n.misoOe = !masterSelectBit && enable && !syn[SY_SSN];
		// receiver input follows the role, format settings shared
		inBit = masterSelectBit ? syn[SY_MISO] : syn[SY_MOSI];

		if (!masterSelectBit || !enable) begin
			// baud counter held, clock parked at idle level
			n.fsm = ST_IDLE;
			n.cnt = 8'h00;
			n.csN = CS_IDLE;
			n.sclkQ = clockIdleLevel;
		end

		// master sequencer, paced by the baud divisor
		if (masterSelectBit && enable) begin
			case (s.fsm)
				ST_IDLE: begin
					n.sclkQ = clockIdleLevel;
					n.csN = CS_IDLE;
					if (!s.txHoldingEmpty) begin
						startXfer = 1'b1;
					end
				end
				ST_LEAD: begin
					if (halfDone(s.cnt, baudDivisor)) begin
						n.cnt = 8'h00;
						n.sclkQ = ~clockIdleLevel;
						lead = 1'b1;
						n.fsm = ST_TRAIL;
					end else begin
						n.cnt = s.cnt + 8'h01;
					end
				end
				ST_TRAIL: begin
					if (halfDone(s.cnt, baudDivisor)) begin
						n.cnt = 8'h00;
						n.sclkQ = clockIdleLevel;
						trail = 1'b1;
						n.fsm = (s.bitCnt == LAST_BIT) ? ST_GAP : ST_LEAD;
					end else begin
						n.cnt = s.cnt + 8'h01;
					end
				end
				ST_GAP: begin
					if (s.cnt >= interTransferDelay) begin
						if (!s.txHoldingEmpty) begin
							startXfer = 1'b1;
						end else begin
							n.fsm = ST_IDLE;
							n.csN = CS_IDLE;
							n.txAllDone = 1'b1;
						end
					end else begin
						n.cnt = s.cnt + 8'h01;
					end
				end
				default: begin
					n.fsm = ST_IDLE;
				end
			endcase
		end

		// load the waiting word and open a master transfer
		if (startXfer) begin
			n.sh = s.hold;
			n.txHoldingEmpty = 1'b1;
			n.outBit = s.hold[MSB];
			n.bitCnt = 3'h0;
			n.cnt = 8'h00;
			n.fsm = ST_LEAD;
			n.csN = csDecode(peripheralSelectField);
			n.txAllDone = 1'b0;
		end

		// slave: edges come from the synchronised external clock
		if (!masterSelectBit && enable) begin
			if (syn[SY_SSN]) begin
				n.bitCnt = 3'h0;
			end else begin
				if (s.ssnP) begin
					// selection starts: present first bit
					n.txAllDone = 1'b0;
					if (!s.txHoldingEmpty) begin
						n.sh = s.hold;
						n.txHoldingEmpty = 1'b1;
						n.outBit = s.hold[MSB];
					end else begin
						n.outBit = s.sh[MSB];
					end
				end else if (syn[SY_SCLK] != s.sclkP) begin
					lead = (syn[SY_SCLK] != clockIdleLevel);
					trail = (syn[SY_SCLK] == clockIdleLevel);
				end
			end
		end

		// shared shift actions, edge roles set by the phase bit
		if (lead) begin
			if (captureLeadingEdge) begin
				n.sample = inBit;
			end else begin
				n.outBit = s.sh[MSB];
			end
		end
		if (trail) begin
			shNew = shiftIn(s.sh, captureLeadingEdge ? s.sample : inBit);
			n.sh = shNew;
			if (captureLeadingEdge) begin
				n.outBit = shNew[MSB];
			end
			n.bitCnt = s.bitCnt + 3'h1;
			if (s.bitCnt == LAST_BIT) begin
				rxLoad = 1'b1;
				if (!masterSelectBit) begin
					if (!s.txHoldingEmpty) begin
						n.sh = s.hold;
						n.txHoldingEmpty = 1'b1;
						if (captureLeadingEdge) begin
							n.outBit = s.hold[MSB];
						end
					end else begin
						n.txAllDone = 1'b1;
					end
				end
			end
		end

		// receive flags: clears first so that a set wins
		if (rxRead) begin
			n.rxHoldingFull = 1'b0;
		end
		if (statusRead) begin
			n.rxOverrunFlag = 1'b0;
		end
		if (rxLoad) begin
			n.rx = shNew;
			n.rxHoldingFull = 1'b1;
			if (s.rxHoldingFull && !rxRead) begin
				n.rxOverrunFlag = 1'b1;
			end
		end

		// a write lands in the holding register after any load
		if (txWrite) begin
			n.hold = txData;
			n.txHoldingEmpty = 1'b0;
		end

		// interrupt from enabled flags: overrun, full, done, empty
		n.irq = |({n.rxOverrunFlag, n.rxHoldingFull, n.txAllDone,
			n.txHoldingEmpty} & intEnable);
	end

	// state register
	always_ff @(posedge clock) begin
		if (srst) begin
			s <= SMC_RESET;
		end else begin
			s <= n;
		end
	end

	// outputs straight from the state flops
	assign rxData = s.rx;
	assign txHoldingEmpty = s.txHoldingEmpty;
	assign dmaTxReq = s.txHoldingEmpty;
	assign txAllDone = s.txAllDone;
	assign rxHoldingFull = s.rxHoldingFull;
	assign rxOverrunFlag = s.rxOverrunFlag;
	assign irq = s.irq;
	assign sclkOut = s.sclkQ;
	assign sclkOe = s.sclkOe;
	assign mosiOut = s.outBit;
	assign mosiOe = s.mosiOe;
	assign misoOut = s.outBit;
	assign misoOe = s.misoOe;
	assign chipSelectN = s.csN;
	assign chipSelectOe = s.csOe;

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	chk_master_pins_on: assert property (
		masterSelectBit |=> (sclkOe && mosiOe && !misoOe &&
			chipSelectOe == CS_ALL_OE))
		else $error("master mode pin directions wrong");

	chk_slave_pins_off: assert property (
		!masterSelectBit |=> (!sclkOe && !mosiOe))
		else $error("slave mode drives clock or MOSI");

	chk_slave_cs_free: assert property (
		!masterSelectBit |=> (chipSelectOe == CS_NO_OE))
		else $error("slave mode drives a chip select");

	chk_baud_slave_held: assert property (
		!masterSelectBit |=> (s.cnt == 8'h00 && s.fsm == ST_IDLE))
		else $error("baud counter runs in slave mode");

	chk_idle_clock_level: assert property (
		(masterSelectBit && enable && s.fsm == ST_IDLE)
		|=> (sclkOut == $past(clockIdleLevel)))
		else $error("idle clock level wrong");

	chk_capture_trail: assert property (
		(trail && !captureLeadingEdge &&
		!(rxLoad && !masterSelectBit && !s.txHoldingEmpty))
		|=> (s.sh[0] == $past(inBit)))
		else $error("input bit not shifted in");

	chk_tx_holding_empty_on_write: assert property (
		txWrite |=> (!txHoldingEmpty && s.hold == $past(txData)))
		else $error("write did not fill holding register");

	chk_back_to_back: assert property (
		(masterSelectBit && enable && s.fsm == ST_GAP &&
		s.cnt >= interTransferDelay && !s.txHoldingEmpty && !txWrite)
		|=> (s.fsm == ST_LEAD && txHoldingEmpty && !txAllDone))
		else $error("waiting word did not start");

	// only the master inserts a gap before transfer-done
	chk_done_after_gap: assert property (
		(rxLoad && masterSelectBit) |=> !txAllDone)
		else $error("transfer-done set before the delay");

	chk_rx_full_read: assert property (
		(rxRead && !rxLoad) |=> !rxHoldingFull)
		else $error("receive-full not cleared by read");

	chk_overrun_sticky: assert property (
		(rxOverrunFlag && !statusRead) |=> rxOverrunFlag)
		else $error("overrun cleared without status read");

	chk_overrun_set: assert property (
		(rxLoad && rxHoldingFull && !rxRead) |=> (rxOverrunFlag &&
		rxData == $past(shNew)))
		else $error("overrun not flagged or data not updated");

endmodule : smc_core

// File: src/smc_sync.sv
// Purpose: two-flop synchroniser for the serial pin inputs
// Assumes: inputs are asynchronous to clock
// Notes: the first stage is read only by the second stage
module smc_sync import smc_pkg::*; (
	input wire logic clock,
	input wire logic srst,
	input wire logic [SYNC_W-1:0] pinIn,
	output logic [SYNC_W-1:0] pinSync
);
	smc_sync_t s;
	smc_sync_t n;

	// next stage values
	always_comb begin
		n = s;
		n.meta = pinIn;
		n.stable = s.meta;
	end

	// stage registers
	always_ff @(posedge clock) begin
		if (srst) begin
			s <= SYNC_RESET;
		end else begin
			s <= n;
		end
	end

	assign pinSync = s.stable;

endmodule : smc_sync
